// [sar_frame_pkg.sv]
package sar_frame_pkg;
    localparam int CMD_BITS         = 16;
    localparam int RESULT_BITS      = 18;
    localparam int CHANNEL_W        = 3;
    localparam int REG_DATA_W       = 8;
    localparam int REG_COUNT        = 4;
    localparam int REG_ADDR_W       = 2;
    localparam int SYS_CLK_MHZ      = 50;
    localparam int CONV_TIME_NS     = 1000;
    localparam int CONV_CYCLES      = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SCLK_PERIOD_NS   = 160;
    localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS * SYS_CLK_MHZ) / 2000;
    localparam int SYNC_MARGIN      = 4;
    localparam logic [4:0] CMD_EDGES = 5'h10;
    localparam logic [CMD_BITS-1:0] HOLD_CMD = 16'h0000;
    localparam int REG_ACCESS_BIT   = 15;
    localparam int OP_LSB           = 12;
    localparam logic [3:0] OP_FIXED_CH = 4'hC;
    localparam int CH_LSB           = 7;
    localparam int REG_ADDR_LSB     = 9;
    localparam int REG_WR_BIT       = 8;
    localparam logic [REG_DATA_W-1:0] REGISTER_ACCESS_PHASE_DEFAULT = 8'h00;
    localparam logic [RESULT_BITS-1:0] INVALID_WORD = 18'h3FFFF;
    localparam logic [RESULT_BITS-1:0] IDLE_WORD    = 18'h00000;
    typedef enum logic [3:0] {
        MODE_IDLE    = 4'h1,
        MODE_CONVERT = 4'h2,
        MODE_REGACC  = 4'h4,
        MODE_INVALID = 4'h8
    } mode_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_RUN  = 4'h2,
        H_TAIL = 4'h4,
        H_GAP  = 4'h8
    } host_state_t;
endpackage

// [sar_frame_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sar_frame_if;
    logic csN;
    logic sclk;
    logic sdi;
    logic chainIn;
    logic sdoOut;
    logic sdoEnN;
    logic sdoLine;
    // Released line reads low, as if pulled down
    assign sdoLine = sdoEnN ? 1'b0 : sdoOut;
    modport device (input csN, input sclk, input sdi, input chainIn,
                    output sdoOut, output sdoEnN);
    modport host (output csN, output sclk, output sdi, input sdoLine);
endinterface
`default_nettype wire

// [sar_result_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // System
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // Fill side
    input  wire logic [WIDTH-1:0]   inData,
    input  wire logic               inValid,
    output logic                    inReady,
    // Drain side
    output logic [WIDTH-1:0]        outData,
    output logic                    outValid,
    input  wire logic               outReady,
    output logic [$clog2(DEPTH):0]  level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("FIFO depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW-1:0]    next_wrPtr;
    logic [AW-1:0]    next_rdPtr;
    logic [AW:0]      next_level;
    logic             push;
    logic             pop;

    assign inReady  = level != FULL;
    assign outValid = level != '0;
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb
    begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_level = level + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            level <= next_level;
        end
        if (push)
            mem[wrPtr] <= inData;
    end
endmodule
`default_nettype wire

// [sar_adc_frame_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_frame_host #(
    parameter int CHAIN_LEN  = 1,
    parameter int FIFO_DEPTH = 4,
    parameter int CONV_WAIT  = sar_frame_pkg::CONV_CYCLES + sar_frame_pkg::SYNC_MARGIN
) (
    // System
    input  wire logic                                 sys_clk,
    input  wire logic                                 reset,
    // Serial link
    sar_frame_if.host                                 link,
    // Command request
    input  wire logic [sar_frame_pkg::CMD_BITS-1:0]   cmdWord,
    input  wire logic                                 cmdValid,
    output logic                                      cmdReady,
    // Result stream
    output logic [sar_frame_pkg::RESULT_BITS-1:0]     resultData,
    output logic                                      resultValid,
    input  wire logic                                 resultReady,
    output logic                                      busy
);
    localparam int TOTAL = int'(sar_frame_pkg::CMD_EDGES)
                           + sar_frame_pkg::RESULT_BITS * CHAIN_LEN;
    localparam logic [7:0] LAST_FALL = 8'(TOTAL - 1);
    localparam logic [7:0] CMD_LAST  = 8'(int'(sar_frame_pkg::CMD_EDGES) - 1);
    localparam logic [7:0] CMD_DONE  = 8'(sar_frame_pkg::CMD_EDGES);
    localparam logic [7:0] WAIT_END  = 8'(CONV_WAIT);
    localparam logic [3:0] HALF_LAST = 4'(sar_frame_pkg::SCLK_HALF_CYCLES - 1);
    localparam logic [4:0] BIT_LAST  = 5'(sar_frame_pkg::RESULT_BITS - 1);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam logic [LW-1:0] ROOM_LIMIT = LW'(FIFO_DEPTH - CHAIN_LEN);

    if (CHAIN_LEN < 1 || CHAIN_LEN > FIFO_DEPTH || TOTAL > 255 || CONV_WAIT > 255)
    begin : g_bad_params
        $error("Chain length, FIFO depth or conversion wait out of range");
    end

    sar_frame_pkg::host_state_t state, next_state;
    logic [3:0]  div, next_div;
    logic        sclkLvl, next_sclkLvl;
    logic        csN, next_csN;
    logic        sdi, next_sdi;
    logic [15:0] txShift, next_txShift;
    logic [7:0]  fallCnt, next_fallCnt;
    logic [7:0]  convWait, next_convWait;
    logic [17:0] rxShift, next_rxShift;
    logic [4:0]  bitCnt, next_bitCnt;
    logic        pushValid, next_pushValid;
    logic [17:0] pushData, next_pushData;
    logic [1:0]  sdoSync;
    logic [LW-1:0] level;

    assign link.csN  = csN;
    assign link.sclk = sclkLvl;
    assign link.sdi  = sdi;
    assign busy      = state != sar_frame_pkg::H_IDLE;
    // Whole frame's words are reserved up front, so a push never stalls
    assign cmdReady  = state == sar_frame_pkg::H_IDLE && level <= ROOM_LIMIT;

    sar_result_fifo #(.WIDTH(sar_frame_pkg::RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .inData   (pushData),
        .inValid  (pushValid),
        .inReady  (),
        .outData  (resultData),
        .outValid (resultValid),
        .outReady (resultReady),
        .level    (level)
    );

    always_comb
    begin
        next_state = state;
        next_div = div;
        next_sclkLvl = sclkLvl;
        next_csN = csN;
        next_sdi = sdi;
        next_txShift = txShift;
        next_fallCnt = fallCnt;
        next_convWait = convWait;
        next_rxShift = rxShift;
        next_bitCnt = bitCnt;
        next_pushValid = 1'b0;
        next_pushData = pushData;
        case (state)
            sar_frame_pkg::H_IDLE:
            begin
                // Caller's words pass unchanged; configuration order is its own
                if (cmdValid && cmdReady)
                begin
                    next_state = sar_frame_pkg::H_RUN;
                    next_csN = 1'b0;
                    next_txShift = cmdWord;
                    next_sdi = cmdWord[15];
                    next_div = '0;
                    next_fallCnt = '0;
                    next_convWait = '0;
                    next_bitCnt = '0;
                end
            end
            sar_frame_pkg::H_RUN:
            begin
                if (convWait != WAIT_END)
                    next_convWait = convWait + 8'h01;
                if (div != HALF_LAST)
                    next_div = div + 4'h1;
                else if (!sclkLvl)
                begin
                    next_div = '0;
                    next_sclkLvl = 1'b1;
                    next_txShift = {txShift[14:0], 1'b0};
                    next_sdi = txShift[14];
                end
                else if (!(fallCnt == CMD_LAST && convWait != WAIT_END))
                begin
                    next_div = '0;
                    next_sclkLvl = 1'b0;
                    next_fallCnt = fallCnt + 8'h01;
                    if (fallCnt >= CMD_DONE)
                    begin
                        next_rxShift = {rxShift[16:0], sdoSync[1]};
                        if (bitCnt == BIT_LAST)
                        begin
                            next_bitCnt = '0;
                            next_pushValid = 1'b1;
                            next_pushData = {rxShift[16:0], sdoSync[1]};
                        end
                        else
                            next_bitCnt = bitCnt + 5'h01;
                    end
                    if (fallCnt == LAST_FALL)
                        next_state = sar_frame_pkg::H_TAIL;
                end
            end
            sar_frame_pkg::H_TAIL:
            begin
                next_sdi = 1'b0;
                if (div != HALF_LAST)
                    next_div = div + 4'h1;
                else
                begin
                    next_div = '0;
                    next_sclkLvl = 1'b1;
                    next_csN = 1'b1;
                    next_state = sar_frame_pkg::H_GAP;
                end
            end
            sar_frame_pkg::H_GAP:
            begin
                // Select high long enough for every device to see the rise
                if (div != HALF_LAST)
                    next_div = div + 4'h1;
                else
                    next_state = sar_frame_pkg::H_IDLE;
            end
            default:
                next_state = sar_frame_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        sdoSync <= {sdoSync[0], link.sdoLine};
        if (reset)
        begin
            state <= sar_frame_pkg::H_IDLE;
            div <= '0;
            sclkLvl <= 1'b1;
            csN <= 1'b1;
            sdi <= 1'b0;
            txShift <= '0;
            fallCnt <= '0;
            convWait <= '0;
            rxShift <= '0;
            bitCnt <= '0;
            pushValid <= 1'b0;
            pushData <= '0;
        end
        else
        begin
            state <= next_state;
            div <= next_div;
            sclkLvl <= next_sclkLvl;
            csN <= next_csN;
            sdi <= next_sdi;
            txShift <= next_txShift;
            fallCnt <= next_fallCnt;
            convWait <= next_convWait;
            rxShift <= next_rxShift;
            bitCnt <= next_bitCnt;
            pushValid <= next_pushValid;
            pushData <= next_pushData;
        end
    end
endmodule
`default_nettype wire

// [sar_adc_frame_device.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_frame_device #(
    parameter int CONV_CYCLES = sar_frame_pkg::CONV_CYCLES
) (
    // System
    input  wire logic                                    sys_clk,
    input  wire logic                                    reset,
    // Serial link
    sar_frame_if.device                                  link,
    // Converter side
    input  wire logic [sar_frame_pkg::RESULT_BITS-1:0]   convResult,
    output logic [sar_frame_pkg::CHANNEL_W-1:0]          sampleChannel,
    output logic                                         sampleStrobe,
    output sar_frame_pkg::mode_t                         mode
);
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
    localparam int PAD_W = sar_frame_pkg::RESULT_BITS - sar_frame_pkg::REG_DATA_W;

    if (CONV_CYCLES < 1 || CONV_CYCLES > 256)
    begin : g_bad_conv
        $error("Conversion cycle count out of range");
    end

    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [1:0] csSync;
    logic [1:0] sclkSync;
    logic [1:0] sdiSync;
    logic [1:0] chainSync;
    logic       csLast;
    logic       sclkLast;
    logic       csFall;
    logic       csRise;
    logic       sclkFall;

    sar_frame_pkg::mode_t next_mode;
    logic [sar_frame_pkg::CHANNEL_W-1:0]  next_channel;
    logic                                 next_strobe;
    logic [15:0] cmdShift, next_cmdShift;
    logic [15:0] latchedCmd, next_latchedCmd;
    logic        cmdPending, next_cmdPending;
    logic [4:0]  edgeCnt, next_edgeCnt;
    logic        inFrame, next_inFrame;
    logic [7:0]  convCnt, next_convCnt;
    logic        converting, next_converting;
    logic [17:0] shReg, next_shReg;
    logic        sdoOut, next_sdoOut;
    logic        sdoEnN, next_sdoEnN;
    logic [1:0]  readAddr, next_readAddr;
    logic [7:0]  progReg [sar_frame_pkg::REG_COUNT];
    logic [7:0]  next_progReg [sar_frame_pkg::REG_COUNT];

    assign link.sdoOut = sdoOut;
    assign link.sdoEnN = sdoEnN;
    assign csFall   = csLast && !csSync[1];
    assign csRise   = !csLast && csSync[1];
    assign sclkFall = sclkLast && !sclkSync[1];

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            csSync <= 2'h3;
            sclkSync <= 2'h3;
            sdiSync <= 2'h0;
            chainSync <= 2'h0;
            csLast <= 1'b1;
            sclkLast <= 1'b1;
        end
        else
        begin
            csSync <= {csSync[0], link.csN};
            sclkSync <= {sclkSync[0], link.sclk};
            sdiSync <= {sdiSync[0], link.sdi};
            chainSync <= {chainSync[0], link.chainIn};
            csLast <= csSync[1];
            sclkLast <= sclkSync[1];
        end
    end

    always_comb
    begin
        next_mode = mode;
        next_channel = sampleChannel;
        next_strobe = 1'b0;
        next_cmdShift = cmdShift;
        next_latchedCmd = latchedCmd;
        next_cmdPending = cmdPending;
        next_edgeCnt = edgeCnt;
        next_inFrame = inFrame;
        next_convCnt = convCnt;
        next_converting = converting;
        next_shReg = shReg;
        next_sdoOut = sdoOut;
        next_sdoEnN = sdoEnN;
        next_readAddr = readAddr;
        next_progReg = progReg;

        // Conversion end fills the output register for the current mode
        if (converting)
        begin
            if (convCnt == CONV_LAST)
            begin
                next_converting = 1'b0;
                case (mode)
                    sar_frame_pkg::MODE_CONVERT:
                        next_shReg = convResult;
                    sar_frame_pkg::MODE_REGACC:
                        next_shReg = {progReg[readAddr], PAD_W'(0)};
                    sar_frame_pkg::MODE_INVALID:
                        next_shReg = sar_frame_pkg::INVALID_WORD;
                    default:
                        next_shReg = sar_frame_pkg::IDLE_WORD;
                endcase
            end
            else
                next_convCnt = convCnt + 8'h01;
        end

        if (csFall)
        begin
            next_inFrame = 1'b1;
            next_edgeCnt = '0;
            next_sdoOut = 1'b0;
            next_sdoEnN = 1'b0;
            next_converting = 1'b1;
            next_convCnt = '0;
            // Last frame's command takes effect only now
            if (cmdPending)
            begin
                next_cmdPending = 1'b0;
                if (latchedCmd == sar_frame_pkg::HOLD_CMD)
                begin
                    if (mode == sar_frame_pkg::MODE_REGACC)
                        next_mode = sar_frame_pkg::MODE_IDLE;
                end
                else if (!latchedCmd[sar_frame_pkg::REG_ACCESS_BIT])
                begin
                    next_mode = sar_frame_pkg::MODE_REGACC;
                    next_readAddr = latchedCmd[sar_frame_pkg::REG_ADDR_LSB +: 2];
                    if (latchedCmd[sar_frame_pkg::REG_WR_BIT])
                        next_progReg[latchedCmd[sar_frame_pkg::REG_ADDR_LSB +: 2]] =
                            latchedCmd[7:0];
                end
                else if (latchedCmd[sar_frame_pkg::OP_LSB +: 4] == sar_frame_pkg::OP_FIXED_CH)
                begin
                    next_mode = sar_frame_pkg::MODE_CONVERT;
                    next_channel = latchedCmd[sar_frame_pkg::CH_LSB +: 3];
                end
                else
                    next_mode = sar_frame_pkg::MODE_IDLE;
            end
            // No sampling until a conversion command has arrived
            if (next_mode == sar_frame_pkg::MODE_CONVERT)
                next_strobe = 1'b1;
        end

        if (inFrame && sclkFall)
        begin
            if (edgeCnt < sar_frame_pkg::CMD_EDGES)
            begin
                next_cmdShift = {cmdShift[14:0], sdiSync[1]};
                next_edgeCnt = edgeCnt + 5'h01;
                if (edgeCnt == sar_frame_pkg::CMD_EDGES - 5'h01)
                begin
                    next_latchedCmd = {cmdShift[14:0], sdiSync[1]};
                    next_cmdPending = 1'b1;
                    next_sdoOut = shReg[17];
                end
            end
            else
            begin
                // Same shift serves alone and chained; grounded input gives zeros
                next_shReg = {shReg[16:0], chainSync[1]};
                next_sdoOut = shReg[16];
            end
        end

        if (csRise)
        begin
            next_inFrame = 1'b0;
            next_sdoEnN = 1'b1;
            next_sdoOut = 1'b0;
            if (inFrame && next_edgeCnt < sar_frame_pkg::CMD_EDGES)
            begin
                next_mode = sar_frame_pkg::MODE_INVALID;
                next_cmdPending = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            mode <= sar_frame_pkg::MODE_IDLE;
            sampleChannel <= '0;
            sampleStrobe <= 1'b0;
            cmdShift <= '0;
            latchedCmd <= '0;
            cmdPending <= 1'b0;
            edgeCnt <= '0;
            inFrame <= 1'b0;
            convCnt <= '0;
            converting <= 1'b0;
            shReg <= '0;
            sdoOut <= 1'b0;
            sdoEnN <= 1'b1;
            readAddr <= '0;
            for (int i = 0; i < sar_frame_pkg::REG_COUNT; i++)
                progReg[i] <= sar_frame_pkg::REGISTER_ACCESS_PHASE_DEFAULT;
        end
        else
        begin
            mode <= next_mode;
            sampleChannel <= next_channel;
            sampleStrobe <= next_strobe;
            cmdShift <= next_cmdShift;
            latchedCmd <= next_latchedCmd;
            cmdPending <= next_cmdPending;
            edgeCnt <= next_edgeCnt;
            inFrame <= next_inFrame;
            convCnt <= next_convCnt;
            converting <= next_converting;
            shReg <= next_shReg;
            sdoOut <= next_sdoOut;
            sdoEnN <= next_sdoEnN;
            readAddr <= next_readAddr;
            progReg <= next_progReg;
        end
    end
endmodule
`default_nettype wire

// [sar_frame_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_frame_asserts #(
    parameter int CONV_CYCLES = 50
) (
    // System
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic chainIn,
    input wire logic sdoOut,
    input wire logic sdoEnN,
    input wire logic sdoLine
);
    // Counted at the pins; the device answers a few clocks later
    logic       prevSclk;
    logic       sclkFell;
    logic [5:0] fallCnt;
    logic [5:0] next_fallCnt;
    logic [7:0] csCyc;
    logic [7:0] next_csCyc;
    always_comb
    begin
        sclkFell = prevSclk && !sclk;
        next_fallCnt = csN ? 6'h00 : fallCnt + {5'h00, sclkFell};
        next_csCyc = csN ? 8'h00 : csCyc + {7'h00, csCyc != 8'hFF};
    end
    always_ff @(posedge sys_clk)
    begin
        prevSclk <= reset | sclk;
        fallCnt <= reset ? 6'h00 : next_fallCnt;
        csCyc <= reset ? 8'h00 : next_csCyc;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_open;
        ##[1:6] !sdoEnN;
    endsequence
    sequence s_tail;
        ##5 (!sdoOut) [*4];
    endsequence
    property p_open; $fell(csN) |-> s_open; endproperty
    a_open: assert property (p_open) else $error("output not driven in frame");
    property p_release; $rose(csN) |-> ##[1:6] sdoEnN; endproperty
    a_release: assert property (p_release) else $error("output not released");
    property p_cmdLow; (!csN && fallCnt < 6'd16) |-> !sdoLine; endproperty
    a_cmdLow: assert property (p_cmdLow) else $error("output high in command phase");
    property p_tail; (sclkFell && fallCnt == 6'd33 && !chainIn) |-> s_tail; endproperty
    a_tail: assert property (p_tail) else $error("output not low after result");
    property p_inFrame; $fell(sclk) |-> !csN; endproperty
    a_inFrame: assert property (p_inFrame) else $error("clock fall outside frame");
    property p_sdi; $fell(sclk) |-> $stable(sdi); endproperty
    a_sdi: assert property (p_sdi) else $error("input moved at clock fall");
    property p_conv; (sclkFell && fallCnt == 6'd15) |-> int'(csCyc) >= CONV_CYCLES; endproperty
    a_conv: assert property (p_conv) else $error("result edge before conversion end");
    property p_len; $rose(csN) |-> fallCnt == 6'd34; endproperty
    a_len: assert property (p_len) else $error("wrong fall count in frame");
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 sys_clk;
    logic                 reset;
    logic [15:0]          cmdWord;
    logic                 cmdValid;
    logic                 cmdReady;
    logic [17:0]          resultData;
    logic                 resultValid;
    logic                 resultReady;
    logic                 busy;
    logic [2:0]           ch;
    logic [2:0]           ch2;
    logic [35:0]          got;
    logic                 strobe;
    sar_frame_pkg::mode_t mode;
    int                   numErrors;
    int                   nTests;
    int                   cycles;
    int                   strobes;
    sar_frame_if lnk ();
    sar_frame_if lnk2 ();
    function automatic logic [17:0] expw(input logic [2:0] c);
        return {c, 15'h4C3A};
    endfunction
    sar_adc_frame_host sar_adc_frame_host_inst (.sys_clk(sys_clk), .reset(reset), .link(lnk),
        .cmdWord(cmdWord), .cmdValid(cmdValid), .cmdReady(cmdReady), .resultData(resultData),
        .resultValid(resultValid), .resultReady(resultReady), .busy(busy));
    sar_adc_frame_device sar_adc_frame_device_inst (.sys_clk(sys_clk), .reset(reset),
        .link(lnk), .convResult(expw(ch)), .sampleChannel(ch), .sampleStrobe(strobe), .mode(mode));
    // Second end on a bench-driven link, for chain data and aborted frames
    sar_adc_frame_device sar_adc_frame_device_inst2 (.sys_clk(sys_clk), .reset(reset),
        .link(lnk2), .convResult(expw(ch2)), .sampleChannel(ch2), .sampleStrobe(), .mode());
    sar_frame_asserts #(.CONV_CYCLES(sar_frame_pkg::CONV_CYCLES)) sar_frame_asserts_inst (
        .sys_clk(sys_clk), .reset(reset), .csN(lnk.csN), .sclk(lnk.sclk), .sdi(lnk.sdi),
        .chainIn(lnk.chainIn), .sdoOut(lnk.sdoOut), .sdoEnN(lnk.sdoEnN), .sdoLine(lnk.sdoLine));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (strobe === 1'b1)
            strobes++;
        if (cycles == 40000)
        begin
            numErrors++;
            stopTest();
        end
    end
    task automatic stopTest();
        $display("checks %0d errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [17:0] e, input logic [17:0] s);
        nTests++;
        if (s !== e)
        begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic send(input logic [15:0] c);
        int k;
        k = 0;
        cmdWord = c;
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1 && k++ < 3000)
            tick(1);
        tick(1);
        cmdValid = 1'b0;
        tick(1);
    endtask
    task automatic take(input logic [17:0] e, input logic chk);
        int k;
        k = 0;
        resultReady = 1'b1;
        while (resultValid !== 1'b1 && k++ < 3000)
            tick(1);
        if (chk)
            check("result", e, resultData);
        tick(1);
        resultReady = 1'b0;
        tick(1);
    endtask
    // Input after fall 16 is driven high on purpose: the device must ignore it
    task automatic bang(input logic [15:0] c, input int nf, input logic [17:0] ci);
        int i;
        lnk2.csN = 1'b0;
        for (i = 1; i <= nf; i++)
        begin
            lnk2.sclk = 1'b1;
            lnk2.sdi = (i <= 16) ? c[16-i] : 1'b1;
            lnk2.chainIn = (i > 16 && i < 35) ? ci[34-i] : 1'b0;
            tick(i == 16 ? 60 : 4);
            lnk2.sclk = 1'b0;
            if (i > 16)
                got = {got[34:0], lnk2.sdoLine};
            tick(4);
        end
        lnk2.sclk = 1'b1;
        lnk2.csN = 1'b1;
        tick(8);
    endtask
    initial
    begin
        reset = 1'b1;
        cmdWord = 16'h0000;
        cmdValid = 1'b0;
        resultReady = 1'b0;
        got = 36'h000000000;
        lnk.chainIn = 1'b0;
        lnk2.csN = 1'b1;
        lnk2.sclk = 1'b1;
        lnk2.sdi = 1'b0;
        lnk2.chainIn = 1'b0;
        tick(8);
        reset = 1'b0;
        tick(2);
        check("mode", 18'(sar_frame_pkg::MODE_IDLE), 18'(mode));
        check("busy", 18'h00000, 18'(busy));
        send(16'h0000);
        check("busy", 18'h00001, 18'(busy));
        take(18'h00000, 1'b1);
        for (int c = 0; c < 8; c++)
        begin
            send(16'hC000 | (16'(c) << 7));
            take(c == 0 ? 18'h00000 : expw(3'(c - 1)), 1'b1);
        end
        send(16'h0000);
        take(expw(3'h7), 1'b1);
        send(16'h05A5);
        take(expw(3'h7), 1'b1);
        send(16'h0400);
        take(18'h29400, 1'b1);
        send(16'h0200);
        take(18'h29400, 1'b1);
        send(16'h0000);
        take(18'h00000, 1'b1);
        send(16'h0400);
        take(18'h00000, 1'b1);
        check("mode", 18'(sar_frame_pkg::MODE_IDLE), 18'(mode));
        send(16'h0000);
        take(18'h29400, 1'b1);
        send(16'hC180);
        take(18'h00000, 1'b1);
        for (int c = 0; c < 4; c++)
            send(16'h0000);
        tick(600);
        check("ready", 18'h00000, 18'(cmdReady));
        for (int c = 0; c < 4; c++)
            take(expw(3'h3), 1'b1);
        // Thirteen frames opened in convert mode so far
        check("strobes", 18'h0000D, 18'(strobes));
        send(16'h8000);
        take(expw(3'h3), 1'b1);
        send(16'h0000);
        take(18'h00000, 1'b1);
        check("mode", 18'(sar_frame_pkg::MODE_IDLE), 18'(mode));
        bang(16'hC300, 34, 18'h00000);
        check("idle word", 18'h00000, got[17:0]);
        bang(16'h0000, 52, 18'h2D3C1);
        check("own word", expw(3'h6), got[35:18]);
        check("chained word", 18'h2D3C1, got[17:0]);
        check("release", 18'h00001, 18'(lnk2.sdoEnN));
        bang(16'h0000, 10, 18'h00000);
        bang(16'h0000, 34, 18'h00000);
        check("invalid", sar_frame_pkg::INVALID_WORD, got[17:0]);
        bang(16'hC300, 34, 18'h00000);
        check("invalid", sar_frame_pkg::INVALID_WORD, got[17:0]);
        bang(16'h0000, 34, 18'h00000);
        check("recovered", expw(3'h6), got[17:0]);
        stopTest();
    end
endmodule
`default_nettype wire
